/* hdl/fnacc_map.vh */
// constants for the fractional-n bcd accumulator
`ifndef FNACC_MAP_VH
`define FNACC_MAP_VH
`define FNACC_RING_LEN 10
`define FNACC_HALF_LEN 5
`define FNACC_RING_START 10'h001
`define FNACC_IDX_LAST 3'h4
`define FNACC_IDX_ZERO 3'h0
`define FNACC_IDX_STEP 3'h1
`define FNACC_FIRST_STAGES 4
`define FNACC_SECOND_STAGES 5
`define FNACC_BCD_MAX 5'h09
`define FNACC_BCD_FIX 5'h06
`define FNACC_NIB_ZERO 4'h0
`define FNACC_NIB_ONE 4'h1
`define FNACC_NIB_NINE 4'h9
`define FNACC_CNT_ZERO 8'h00
`define FNACC_CNT_ONE 8'h01
`define FNACC_SHIFT_W 32
`define FNACC_SHIFT_ZERO 32'h00000000
`define FNACC_FRAC_LO 0
`define FNACC_FRAC_HI 19
`define FNACC_D100K_LO 20
`define FNACC_D100K_HI 23
`define FNACC_D1M_LO 24
`define FNACC_D1M_HI 27
`define FNACC_D10M_LO 28
`define FNACC_D10M_HI 31
`define FNACC_SYNC_W 5
`define FNACC_S_REF 0
`define FNACC_S_SDATA 1
`define FNACC_S_SCLK 2
`define FNACC_S_STRB 3
`define FNACC_S_PRESC 4
`endif

/* hdl/fnacc_bcd_add.v */
// one bcd digit adder with carry in and carry out
`timescale 1ns/10ps
`include "fnacc_map.vh"
module fnacc_bcd_add
(
    input wire [3:0] a_in,
    input wire [3:0] b_in,
    input wire carry_in,
    output reg [3:0] sum_out,
    output reg carry_out
);
    reg [4:0] raw;
    reg [4:0] fixed;

    // past nine the digit wraps through zero and a carry leaves
    always @*
    begin
        raw = {1'b0, a_in} + {1'b0, b_in} + {4'h0, carry_in};
        fixed = raw + `FNACC_BCD_FIX;
        if (raw > `FNACC_BCD_MAX)
        begin
            sum_out = fixed[3:0];
            carry_out = 1'b1;
        end
        else
        begin
            sum_out = raw[3:0];
            carry_out = 1'b0;
        end
    end
endmodule // fnacc_bcd_add

/* hdl/fnacc_top.v */
// digital control of the fractional-n synthesizer: accumulator and divider
`timescale 1ns/10ps
`include "fnacc_map.vh"
module fnacc_top
(
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire ref_1mhz_in,
    input wire ser_data_in,
    input wire ser_clock_in,
    input wire ser_strobe_in,
    input wire presc_out_in,
    output reg modulus_control_first_out,
    output reg modulus_control_second_out,
    output reg div_var_out,
    output reg div_var_n_out,
    output reg phase_ref_out,
    output reg half_sel_out,
    output reg carry_pulse_out,
    output reg [3:0] int_digit_out,
    output reg [3:0] digit_1m_out,
    output reg [3:0] digit_10m_out,
    output reg [3:0] dac_a_out,
    output reg [3:0] dac_b_out
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage one is read only by stage two
    reg [`FNACC_SYNC_W-1:0] sync1_q;
    reg [`FNACC_SYNC_W-1:0] sync2_q;
    reg [`FNACC_SYNC_W-1:0] sync3_q;
    wire tick;
    wire sclk_rise;
    wire strobe_rise;
    wire presc_rise;
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_q <= {`FNACC_SYNC_W{1'b0}};
            sync2_q <= {`FNACC_SYNC_W{1'b0}};
            sync3_q <= {`FNACC_SYNC_W{1'b0}};
        end
        else
        begin
            sync1_q <= {presc_out_in, ser_strobe_in, ser_clock_in,
                        ser_data_in, ref_1mhz_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // rising edges of the synchronised pins other than serial data, one sys clock wide
    assign tick = sync2_q[`FNACC_S_REF] & ~sync3_q[`FNACC_S_REF];
    assign sclk_rise = sync2_q[`FNACC_S_SCLK] & ~sync3_q[`FNACC_S_SCLK];
    assign strobe_rise = sync2_q[`FNACC_S_STRB] & ~sync3_q[`FNACC_S_STRB];
    assign presc_rise = sync2_q[`FNACC_S_PRESC] & ~sync3_q[`FNACC_S_PRESC];
    ////////////////////////////////////////////////////////////////////////
    // serial load: shift chain, strobe delayed one cycle, then parallel load
    reg [`FNACC_SHIFT_W-1:0] shift_q;
    reg [`FNACC_SHIFT_W-1:0] digits_q;
    reg strobe_dly_q;
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            shift_q <= `FNACC_SHIFT_ZERO;
            digits_q <= `FNACC_SHIFT_ZERO;
            strobe_dly_q <= 1'b0;
        end
        else
        begin
            if (sclk_rise)
                shift_q <= {sync2_q[`FNACC_S_SDATA],
                            shift_q[`FNACC_SHIFT_W-1:1]};
            strobe_dly_q <= strobe_rise;
            if (strobe_dly_q)
                digits_q <= shift_q; // one decade per nibble, 1 Hz lowest
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ten-state ring counter on the 1 mhz reference and half control
    reg [`FNACC_RING_LEN-1:0] ring_q;
    reg half_q;
    reg [2:0] idx_q;
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ring_q <= `FNACC_RING_START;
            half_q <= 1'b0;
            idx_q <= `FNACC_IDX_ZERO;
        end
        else if (tick)
        begin
            ring_q <= {ring_q[`FNACC_RING_LEN-2:0],
                       ring_q[`FNACC_RING_LEN-1]};
            if (idx_q == `FNACC_IDX_LAST)
            begin
                idx_q <= `FNACC_IDX_ZERO;
                half_q <= ~half_q; // five clocks each half, endless
            end
            else
                idx_q <= idx_q + `FNACC_IDX_STEP;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // operand selection for the accumulating adder
    reg [3:0] stored_digit;
    reg [3:0] b_operand;
    reg [3:0] stage1_q [0:`FNACC_FIRST_STAGES-1];
    reg [3:0] stage2_q [0:`FNACC_SECOND_STAGES-1];
    wire [3:0] four_out;
    wire [3:0] five_out;
    assign four_out = stage1_q[`FNACC_FIRST_STAGES-1];
    assign five_out = stage2_q[`FNACC_SECOND_STAGES-1];
    // digit storage drives b only in the first half, buffer only in second
    always @*
    begin
        case (idx_q)
            3'h0: stored_digit = digits_q[3:0];
            3'h1: stored_digit = digits_q[7:4];
            3'h2: stored_digit = digits_q[11:8];
            3'h3: stored_digit = digits_q[15:12];
            3'h4: stored_digit = digits_q[19:16];
            default: stored_digit = `FNACC_NIB_ZERO;
        endcase
        if (half_q)
            b_operand = four_out; // recirculated first-pass results
        else
            b_operand = stored_digit; // one digit per ring step
    end
    ////////////////////////////////////////////////////////////////////////
    // accumulating adder, sum latch and carry feedback
    reg [3:0] sum_latch_q;
    reg carry_latch_q;
    wire [3:0] acc_sum;
    wire acc_carry;
    wire carry_into_acc;
    // a digit's carry must not leak into the first digit of the next half
    assign carry_into_acc = carry_latch_q & (idx_q != `FNACC_IDX_ZERO);
    fnacc_bcd_add acc_adder
    (
        .a_in(five_out),
        .b_in(b_operand),
        .carry_in(carry_into_acc),
        .sum_out(acc_sum),
        .carry_out(acc_carry)
    );
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sum_latch_q <= `FNACC_NIB_ZERO;
            carry_latch_q <= 1'b0;
        end
        else if (tick)
        begin
            sum_latch_q <= acc_sum; // wrapped digit, carry kept apart
            carry_latch_q <= acc_carry; // reclocked to next digit
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // delay sections: four stages feeding five stages
    integer i;
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (i = 0; i < `FNACC_FIRST_STAGES; i = i + 1)
                stage1_q[i] <= `FNACC_NIB_ZERO;
            for (i = 0; i < `FNACC_SECOND_STAGES; i = i + 1)
                stage2_q[i] <= `FNACC_NIB_ZERO;
        end
        else if (tick)
        begin
            stage1_q[0] <= sum_latch_q;
            for (i = 1; i < `FNACC_FIRST_STAGES; i = i + 1)
                stage1_q[i] <= stage1_q[i-1];
            stage2_q[0] <= four_out; // four-stage output into five
            for (i = 1; i < `FNACC_SECOND_STAGES; i = i + 1)
                stage2_q[i] <= stage2_q[i-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow carry: caught on the last digit, realigned, then applied
    reg ovf_catch_q;
    reg ovf_align_q;
    wire [3:0] int_sum;
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ovf_catch_q <= 1'b0;
            ovf_align_q <= 1'b0;
            carry_pulse_out <= 1'b0;
        end
        else
        begin
            carry_pulse_out <= tick & acc_carry; // one sys clock pulse
            if (tick)
            begin
                // only the top digit's carry counts as overflow
                ovf_catch_q <= acc_carry & (idx_q == `FNACC_IDX_LAST);
                ovf_align_q <= ovf_catch_q; // further latch stage
            end
        end
    end

    // the integer digit wraps like any bcd decade; its carry is unused
    fnacc_bcd_add int_adder
    (
        .a_in(digits_q[`FNACC_D100K_HI:`FNACC_D100K_LO]),
        .b_in(`FNACC_NIB_ZERO),
        .carry_in(ovf_align_q),
        .sum_out(int_sum),
        .carry_out()
    );

    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            int_digit_out <= `FNACC_NIB_ZERO;
            digit_1m_out <= `FNACC_NIB_ZERO;
            digit_10m_out <= `FNACC_NIB_ZERO;
            half_sel_out <= 1'b0;
        end
        else
        begin
            int_digit_out <= int_sum; // changes with each overflow carry
            digit_1m_out <= digits_q[`FNACC_D1M_HI:`FNACC_D1M_LO];
            digit_10m_out <= digits_q[`FNACC_D10M_HI:`FNACC_D10M_LO];
            half_sel_out <= half_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // four by four result store feeding the dac
    reg [3:0] store_q [0:3];
    reg word_pair_select_q;
    reg write_enable_q;
    wire [1:0] wr_addr;
    wire half_end;
    integer j;
    assign half_end = tick & (idx_q == `FNACC_IDX_LAST);
    // pair from the toggle, word a or b from the half
    assign wr_addr = {word_pair_select_q, half_q};
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (j = 0; j < 4; j = j + 1)
                store_q[j] <= `FNACC_NIB_ZERO;
            word_pair_select_q <= 1'b0;
            write_enable_q <= 1'b0;
            dac_a_out <= `FNACC_NIB_ZERO;
            dac_b_out <= `FNACC_NIB_ZERO;
        end
        else
        begin
            write_enable_q <= half_end;
            if (half_end)
                store_q[wr_addr] <= five_out;
            // halved control: all four words over two accumulations
            if (half_end & half_q)
                word_pair_select_q <= ~word_pair_select_q;
            // outputs move only while write enable is high
            if (write_enable_q)
            begin
                dac_a_out <= store_q[{word_pair_select_q, 1'b0}];
                dac_b_out <= store_q[{word_pair_select_q, 1'b1}];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // three-decade divider on prescaler edges, ten/eleven modulus
    reg [3:0] unit_cnt_q;
    reg [7:0] upper_cnt_q;
    reg div_pulse_q;
    reg mod_ctl_q;
    wire unit_tc;
    wire [7:0] upper_load;
    assign unit_tc = (unit_cnt_q == `FNACC_NIB_ZERO);
    // 10 mhz and 1 mhz digits as a binary count of prescaler cycles
    assign upper_load = ({4'h0, digits_q[`FNACC_D10M_HI:`FNACC_D10M_LO]} << 3)
                      + ({4'h0, digits_q[`FNACC_D10M_HI:`FNACC_D10M_LO]} << 1)
                      + {4'h0, digits_q[`FNACC_D1M_HI:`FNACC_D1M_LO]};
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            unit_cnt_q <= `FNACC_NIB_ZERO;
            upper_cnt_q <= `FNACC_CNT_ZERO;
            div_pulse_q <= 1'b0;
            mod_ctl_q <= 1'b0;
        end
        else if (presc_rise)
        begin
            mod_ctl_q <= ~unit_tc; // divide by eleven until tc, inverted
            if (upper_cnt_q <= `FNACC_CNT_ONE)
            begin
                upper_cnt_q <= upper_load; // programmed by the digits
                unit_cnt_q <= int_digit_out;
                div_pulse_q <= 1'b1;
            end
            else
            begin
                upper_cnt_q <= upper_cnt_q - `FNACC_CNT_ONE;
                if (!unit_tc)
                    unit_cnt_q <= unit_cnt_q - `FNACC_NIB_ONE;
                div_pulse_q <= 1'b0;
            end
        end
    end

    // reclocked divider and reference go to the phase comparator
    always @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            modulus_control_first_out <= 1'b0;
            modulus_control_second_out <= 1'b0;
            div_var_out <= 1'b0;
            div_var_n_out <= 1'b1;
            phase_ref_out <= 1'b0;
        end
        else
        begin
            modulus_control_first_out <= mod_ctl_q;
            modulus_control_second_out <= mod_ctl_q;
            if (presc_rise)
            begin
                div_var_out <= div_pulse_q;
                div_var_n_out <= ~div_pulse_q;
            end
            if (tick) // ring's upper five states, reclocked
                phase_ref_out <= |ring_q[`FNACC_RING_LEN-1:`FNACC_HALF_LEN];
        end
    end
endmodule // fnacc_top

/* testbench/fnacc_properties.sv */
// port checker for the fractional-n accumulator top
`timescale 1ns/10ps
module fnacc_checker
(
    input wire sys_clk_in,
    input wire reset_n_in,
    input wire ref_1mhz_in,
    input wire ser_strobe_in,
    input wire modulus_control_first_out,
    input wire modulus_control_second_out,
    input wire div_var_out,
    input wire div_var_n_out,
    input wire phase_ref_out,
    input wire half_sel_out,
    input wire carry_pulse_out,
    input wire [3:0] int_digit_out,
    input wire [3:0] digit_1m_out,
    input wire [3:0] digit_10m_out,
    input wire [3:0] dac_a_out,
    input wire [3:0] dac_b_out
);
reg half_q;
reg ref_q;
reg strb_q;
reg armed_q;
reg [2:0] rises_q;
reg [3:0] since_strb_q;
////////////////////////////////////////
// the strobe counter starts saturated so nothing looks recent after reset
always @(posedge sys_clk_in or negedge reset_n_in)
begin
    if (!reset_n_in)
    begin
        half_q <= 1'b0;
        ref_q <= 1'b0;
        strb_q <= 1'b0;
        armed_q <= 1'b0;
        rises_q <= 3'h0;
        since_strb_q <= 4'hF;
    end
    else
    begin
        half_q <= half_sel_out;
        ref_q <= ref_1mhz_in;
        strb_q <= ser_strobe_in;
        if (half_sel_out != half_q)
        begin
            armed_q <= 1'b1;
            rises_q <= 3'h0;
        end
        else
        begin
            if (ref_1mhz_in && !ref_q && rises_q != 3'h7)
                rises_q <= rises_q + 3'h1;
        end
        if (ser_strobe_in && !strb_q)
            since_strb_q <= 4'h0;
        else if (since_strb_q != 4'hF)
            since_strb_q <= since_strb_q + 4'h1;
    end
end
////////////////////////////////////////
// one clock domain, so clocking and disable are given once
default clocking cb @(posedge sys_clk_in);
endclocking
default disable iff (!reset_n_in);
div_complement_a:
    assert property (div_var_n_out == !div_var_out)
        else $error("divider outputs not complementary");
modulus_pair_a:
    assert property (modulus_control_first_out == modulus_control_second_out)
        else $error("modulus controls differ");
carry_single_a:
    assert property (carry_pulse_out |=> !carry_pulse_out)
        else $error("carry pulse longer than one cycle");
half_length_a:
    assert property ($changed(half_sel_out) && armed_q |-> rises_q == 3'h5)
        else $error("half cycle not five reference ticks");
phase_follow_a:
    assert property ($changed(half_sel_out) |->
        ##[1:30] phase_ref_out == half_sel_out)
        else $error("phase reference did not follow half control");
dac_timing_a:
    assert property ($changed({dac_a_out, dac_b_out}) |->
        $changed(half_sel_out))
        else $error("dac words changed away from a half boundary");
int_bcd_a:
    assert property (int_digit_out <= 4'h9)
        else $error("integer digit left bcd range");
div_pulse_a:
    assert property ($rose(div_var_out) |-> div_var_out [*6])
        else $error("divider pulse too short");
digit_load_a:
    assert property ($changed({digit_1m_out, digit_10m_out}) |->
        since_strb_q <= 4'h8)
        else $error("digits changed without a load strobe");
endmodule // fnacc_checker

bind fnacc_top fnacc_checker u_chk
(
    .sys_clk_in,
    .reset_n_in,
    .ref_1mhz_in,
    .ser_strobe_in,
    .modulus_control_first_out,
    .modulus_control_second_out,
    .div_var_out,
    .div_var_n_out,
    .phase_ref_out,
    .half_sel_out,
    .carry_pulse_out,
    .int_digit_out,
    .digit_1m_out,
    .digit_10m_out,
    .dac_a_out,
    .dac_b_out
);

/* testbench/fnacc_board_model.sv */
// model of the control board and analog loop that drive the pins
`timescale 1ns/10ps
module fnacc_board_model
#(
    parameter REF_HALF = 10,
    parameter PRE_HALF = 4
)
(
    input wire clk_in,
    output reg ref_out,
    output reg presc_out,
    output reg sdata_out,
    output reg sclk_out,
    output reg strobe_out
);
reg framing_q;
// everything quiet at time zero, shift clock idles low
initial
begin
    ref_out = 1'b0;
    presc_out = 1'b0;
    sdata_out = 1'b0;
    sclk_out = 1'b0;
    strobe_out = 1'b0;
    framing_q = 1'b0;
end
// reference and prescaler run free, levels at least four clocks
always
begin
    repeat (REF_HALF) @(posedge clk_in);
    #1 ref_out = ~ref_out;
end
always
begin
    repeat (PRE_HALF) @(posedge clk_in);
    #1 presc_out = ~presc_out;
end
// data wanders outside frames so a stale bit cannot pass as good
always @(posedge clk_in)
    if (!framing_q)
        sdata_out <= ~sdata_out;
// one frame of 32 bits, first bit sent lands in bit 0, then strobe
task load(input [31:0] word_in);
integer i;
begin
    framing_q = 1'b1;
    for (i = 0; i < 32; i = i + 1)
    begin
        @(posedge clk_in);
        #1 sdata_out = word_in[i];
        repeat (4) @(posedge clk_in);
        #1 sclk_out = 1'b1;
        repeat (4) @(posedge clk_in);
        #1 sclk_out = 1'b0;
    end
    repeat (4) @(posedge clk_in);
    #1 strobe_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 strobe_out = 1'b0;
    framing_q = 1'b0;
end
endtask
endmodule // fnacc_board_model

/* testbench/test_fractional_n_bcd_accumulator.sv */
// self-checking bench for the fractional-n accumulator
`timescale 1ns/10ps
module test_fractional_n_bcd_accumulator;
reg sys_clk_in;
reg reset_n_in;
wire ref_w, presc_w, sdata_w, sclk_w, strb_w;
wire mod1, mod2, divv, divn, phref, half, carry;
wire [3:0] int_d, d1m, d10m, dac_a, dac_b;
integer fails, comparisons, cycles;
fnacc_board_model u_board
(
    .clk_in(sys_clk_in),
    .ref_out(ref_w),
    .presc_out(presc_w),
    .sdata_out(sdata_w),
    .sclk_out(sclk_w),
    .strobe_out(strb_w)
);
fnacc_top u_dut
(
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .ref_1mhz_in(ref_w),
    .ser_data_in(sdata_w),
    .ser_clock_in(sclk_w),
    .ser_strobe_in(strb_w),
    .presc_out_in(presc_w),
    .modulus_control_first_out(mod1),
    .modulus_control_second_out(mod2),
    .div_var_out(divv),
    .div_var_n_out(divn),
    .phase_ref_out(phref),
    .half_sel_out(half),
    .carry_pulse_out(carry),
    .int_digit_out(int_d),
    .digit_1m_out(d1m),
    .digit_10m_out(d10m),
    .dac_a_out(dac_a),
    .dac_b_out(dac_b)
);
////////////////////////////////////////
// compare helpers, one for port values and one for event counts
task chk_val(input [31:0] got, input [31:0] exp);
begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task chk_cnt(input integer got, input integer exp);
begin
    comparisons = comparisons + 1;
    if (got != exp)
    begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
// sample after the edge once the design outputs have settled
task step;
begin
    @(posedge sys_clk_in);
    #2;
end
endtask
////////////////////////////////////////
// outputs held at their cleared values while reset is low
task t_reset;
begin
    chk_val({mod1, mod2, divv, divn, phref, half, carry}, 32'h08);
    chk_val({int_d, d1m, d10m, dac_a, dac_b}, 32'h0);
    $display("test reset done");
end
endtask
// zero fraction from a cleared start never carries
task t_zero;
integer n;
begin
    u_board.load(32'h02300000);
    n = 0;
    repeat (1200)
    begin
        step;
        if (carry !== 1'b0)
            n = n + 1;
    end
    chk_cnt(n, 0);
    chk_val(int_d, 32'h3);
    chk_val({d10m, d1m}, 32'h02);
    chk_val({dac_a, dac_b}, 32'h0);
    $display("test zero done");
end
endtask
// two consecutive halves, reference rises counted in each
task t_half;
integer n, k;
reg h, r;
begin
    @(half);
    step;
    for (k = 0; k < 2; k = k + 1)
    begin
        h = half;
        n = 0;
        while (half === h)
        begin
            r = ref_w;
            step;
            if (ref_w && !r)
                n = n + 1;
        end
        chk_cnt(n, 5);
    end
    $display("test half done");
end
endtask
// ratio 123: twelve prescaler periods, three of them at eleven
task t_div;
integer n, m;
reg p, d;
begin
    u_board.load(32'h12300000);
    repeat (2) @(posedge divv);
    step;
    n = 0;
    m = 0;
    d = 1'b1;
    while (!(divv && !d))
    begin
        d = divv;
        p = presc_w;
        step;
        if (presc_w && !p)
        begin
            n = n + 1;
            if (mod1 === 1'b1)
                m = m + 1;
        end
    end
    chk_cnt(n, 12);
    chk_cnt(m, 3);
    $display("test divider done");
end
endtask
// a new setting reaches the 10 mhz and 1 mhz digit outputs
task t_load;
begin
    u_board.load(32'h01046000);
    repeat (8) step;
    chk_val({d10m, d1m}, 32'h01);
    $display("test load done");
end
endtask
// large fraction: carries flow and bump the integer digit by one
task t_carry;
integer n;
reg [3:0] lo, hi;
reg moved;
begin
    u_board.load(32'h00399999);
    repeat (4) step;
    n = 0;
    lo = 4'hF;
    hi = 4'h0;
    moved = 1'b0;
    repeat (1600)
    begin
        step;
        if (carry === 1'b1)
            n = n + 1;
        if (int_d < lo)
            lo = int_d;
        if (int_d > hi)
            hi = int_d;
        if (dac_a !== 4'h0)
            moved = 1'b1;
    end
    chk_val({lo, hi}, 32'h34);
    chk_val(n != 0, 32'h1);
    chk_val(moved, 32'h1);
    $display("test carry done");
end
endtask
////////////////////////////////////////
// verdict in one place, reached from the end or the watchdog
task results;
begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
end
endtask
initial
begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
end
// watchdog sized at about two and a half times the expected run
always @(posedge sys_clk_in)
begin
    cycles = cycles + 1;
    if (cycles == 12000)
    begin
        fails = fails + 1;
        results;
    end
end
initial
begin
    fails = 0;
    comparisons = 0;
    cycles = 0;
    reset_n_in = 1'b0;
    repeat (10) @(posedge sys_clk_in);
    t_reset;
    repeat (10) @(posedge sys_clk_in);
    #1 reset_n_in = 1'b1;
    repeat (4) step;
    t_zero;
    t_half;
    t_div;
    t_load;
    t_carry;
    results;
end
endmodule // test_fractional_n_bcd_accumulator
